// File: bmc_map.vh
// Constants for the asynchronous bus-master cycle sequencer.
// Definitions only; the sequencer and its synchroniser include this header.
`ifndef BMC_MAP_VH
`define BMC_MAP_VH

// ==========================================================================
// Cycle kinds requested by the core
// ==========================================================================
`define BMC_KIND_WRITE     2'h0
`define BMC_KIND_RMW       2'h1
`define BMC_KIND_IACK      2'h2
`define BMC_KIND_BREAKPOINT_INSTRUCTION      2'h3

// ==========================================================================
// Half-clock bus states (even states open on a rising edge)
// ==========================================================================
`define BMC_S0             5'h00
`define BMC_S1             5'h01
`define BMC_S2             5'h02
`define BMC_S3             5'h03
`define BMC_S4             5'h04
`define BMC_S7             5'h07
`define BMC_S9             5'h09
`define BMC_S12            5'h0C
`define BMC_S14            5'h0E
`define BMC_S15            5'h0F
`define BMC_S16            5'h10
`define BMC_S19            5'h13
`define BMC_S21            5'h15

// ==========================================================================
// Cycle class codes and CPU space encoding
// ==========================================================================
`define BMC_CODES_CPU      3'h7
`define BMC_TYPE_IACK      4'hF
`define BMC_TYPE_BREAKPOINT_INSTRUCTION      4'h0
`define BMC_TYPE_LSB       15
`define BMC_AUTOVEC_BASE   8'h18
`define BMC_TAS_BIT        7

// ==========================================================================
// Default widths and timing counts
// ==========================================================================
`define BMC_ADDR_W         23
`define BMC_HALF_DIV       4'h1
`define BMC_GRANT_NEG      4'h3
`define BMC_GRANT_REASSERT 4'h3
`define BMC_SYNC_W         7

`endif

// File: bmc_sync.v
// Two-flop synchroniser for the asynchronous bus inputs.
// Assumes inputs come from pins outside the core_clk domain.
`timescale 1ns/100ps
`include "bmc_map.vh"

module bmc_sync #(
   parameter W = `BMC_SYNC_W
) (
   // Clock and reset
   input  wire         core_clk,
   input  wire         nrst,
   // Raw pins and synchronised levels
   input  wire [W-1:0] pin_in,
   input  wire [W-1:0] rst_val,
   output reg  [W-1:0] sync_out
);

   reg [W-1:0] meta_reg;

   // ======================================================================
   // Synchroniser chain
   // ======================================================================
   // The first stage feeds only the second, so a metastable level never
   // reaches any decision logic.
   always @(posedge core_clk) begin
      if (!nrst) begin
         meta_reg <= {W{1'b1}};
         sync_out <= {W{1'b1}};
      end else begin
         meta_reg <= pin_in;
         sync_out <= meta_reg;
      end
   end

   wire unused_rst_val = |rst_val;

endmodule // bmc_sync

// File: bmc_master.v
// Bus-master cycle sequencer: write, read-modify-write, interrupt and
// breakpoint acknowledge cycles, plus the grant side of bus arbitration.
// Assumes one core clock; each half processor clock is one enable tick.
//
// Contract
// - Word write asserts both byte strobes and drives both data bytes.
// - Byte write picks upper strobe when select bit is zero, lower when one.
// - State zero drives cycle class codes and returns direction to read.
// - Address entering S1; address strobe and write direction at S2; data in S3.
// - Strobes at S4, then whole-clock waits until acknowledge or fault.
// - Entering S7 strobes negate; ending S7 buses float, direction reads.
// - Atomic cycle holds address strobe throughout and moves a single byte.
// - Atomic read follows read timing, captures data entering S7, keeps strobe.
// - States eight to eleven leave every bus signal unchanged.
// - Atomic write from S12 holds codes; write at S14; data at S15.
// - Byte strobe at S16, then whole-clock waits until termination.
// - Entering S19 strobes negate; ending S19 buses float, direction reads.
// - CPU space uses all-ones codes; four address bits give cycle type.
// - Interrupt acknowledge puts level on low address bits, rest high.
// - Interrupt acknowledge asserts both strobes, ignores upper data lines.
// - Autovector or peripheral termination makes vector base plus level.
// - Breakpoint acknowledge is read-like, no data, ended by any termination; the code ignores autovector here.
// - Three-wire grant negates after acknowledge; reasserts if more pending.
// - Two-wire grant stays asserted until the alternate master finishes.
// - Fault without acknowledge ends the cycle one clock later.
`timescale 1ns/100ps
`include "bmc_map.vh"

module bmc_master #(
   parameter       AW            = `BMC_ADDR_W,
   parameter [3:0] HALF_DIV      = `BMC_HALF_DIV,
   parameter [3:0] GRANT_NEG     = `BMC_GRANT_NEG,
   parameter [3:0] GRANT_REASSERT = `BMC_GRANT_REASSERT
) (
   // Clock and reset
   input  wire          core_clk,
   input  wire          nrst,
   // Cycle request from the core
   input  wire          cmd_valid,
   input  wire [1:0]    cmd_kind,
   input  wire          cmd_word,
   input  wire          cmd_byte_select_bit,
   input  wire [AW-1:0] cmd_addr,
   input  wire [2:0]    cmd_class,
   input  wire [2:0]    cmd_level,
   input  wire [15:0]   cmd_wdata,
   output reg           cmd_ready,
   // Cycle completion to the core
   output reg           done,
   output reg           done_fault,
   output reg           done_periph,
   output reg  [7:0]    rd_byte,
   output reg  [7:0]    vector_num,
   // Address and data pins
   output reg  [AW-1:0] addr_out,
   output reg           addr_oe_n,
   output reg  [15:0]   data_out,
   output reg           data_oe_n,
   input  wire [15:0]   data_in,
   // Bus control pins
   output reg           address_valid_strobe_n,
   output reg           upper_byte_strobe_n,
   output reg           lower_byte_strobe_n,
   output reg           rw_read,
   output reg  [2:0]    cycle_class_codes,
   output reg           ctl_oe_n,
   input  wire          transfer_acknowledge_n,
   input  wire          bus_fault_input_n,
   input  wire          legacy_peripheral_valid_n,
   input  wire          autovector_request_n,
   // Arbitration pins
   input  wire          three_wire_mode,
   input  wire          bus_request_n,
   input  wire          grant_acknowledge_n,
   output reg           bus_grant_n
);

   localparam [1:0] ARB_IDLE  = 2'h0;
   localparam [1:0] ARB_GRANT = 2'h1;
   localparam [1:0] ARB_ACKED = 2'h2;
   localparam [1:0] ARB_HELD  = 2'h3;

   // ======================================================================
   // Input synchronisers
   // ======================================================================
   wire [6:0] sync_w;

   bmc_sync #(.W(`BMC_SYNC_W)) bmc_sync_i (
      .core_clk (core_clk),
      .nrst     (nrst),
      .pin_in   ({transfer_acknowledge_n, bus_fault_input_n,
                  legacy_peripheral_valid_n, autovector_request_n,
                  bus_request_n, grant_acknowledge_n, ~three_wire_mode}),
      .rst_val  (7'h7F),
      .sync_out (sync_w)
   );

   wire ack_s   = ~sync_w[6];
   wire fault_s = ~sync_w[5] & sync_w[6];
   wire vpa_s   = ~sync_w[4];
   wire autovector_request_s  = ~sync_w[3];
   wire br_s    = ~sync_w[2];
   wire grant_acknowledge_s = ~sync_w[1] & ~sync_w[0];
   wire three_s = ~sync_w[0];

   // ======================================================================
   // Half-clock enable
   // ======================================================================
   reg  [3:0] div_reg;
   wire       tick = (div_reg == HALF_DIV - 4'h1);

   always @(posedge core_clk) begin
      if (!nrst)
         div_reg <= 4'h0;
      else if (tick)
         div_reg <= 4'h0;
      else
         div_reg <= div_reg + 4'h1;
   end

   // ======================================================================
   // Cycle state
   // ======================================================================
   reg          run_reg;
   reg  [1:0]   kind_reg;
   reg  [4:0]   st_reg;
   reg          wait_reg;
   reg          fault_reg;
   reg          word_reg;
   reg          bsel_reg;
   reg  [AW-1:0] addr_reg;
   reg  [15:0]  wdata_reg;
   reg  [7:0]   byte_reg;
   reg  [2:0]   level_reg;
   reg  [1:0]   arb_reg;
   reg  [3:0]   arb_cnt_reg;
   reg          grant_acknowledge_d_reg;

   wire is_write = (kind_reg == `BMC_KIND_WRITE);
   wire is_rmw   = (kind_reg == `BMC_KIND_RMW);
   wire is_iack  = (kind_reg == `BMC_KIND_IACK);
   wire rmw_wr   = is_rmw & (st_reg >= `BMC_S12);
   wire [4:0] wait_st = rmw_wr ? `BMC_S16 : `BMC_S4;
   // Autovector only means something in an interrupt acknowledge cycle.
   wire periph_s = vpa_s | (is_iack & autovector_request_s);
   wire term_s   = ack_s | fault_s | periph_s;
   // Normal end at S7 or S19; a fault alone pushes it one clock later.
   wire [4:0] neg_st = rmw_wr ? (fault_reg ? `BMC_S21 : `BMC_S19)
                              : (fault_reg ? `BMC_S9  : `BMC_S7);
   wire [4:0] end_st = (is_rmw & ~fault_reg & ~rmw_wr) ? `BMC_S21 : neg_st;

   // Byte lane strobes: both for words and interrupt acknowledges, else by select bit.
   wire both_lanes = word_reg | is_iack;
   wire uds_on = both_lanes | ~bsel_reg;
   wire lds_on = both_lanes |  bsel_reg;
   wire [7:0] lane_byte = bsel_reg ? data_in[7:0] : data_in[15:8];
   wire [7:0] tas_byte  = byte_reg | (8'h01 << `BMC_TAS_BIT);

   wire start = cmd_valid & cmd_ready;
   wire bus_free_for_grant = ~run_reg | (st_reg >= `BMC_S2);

   // CPU space address: cycle type on four bits, level on the low three.
   wire [AW-1:0] iack_addr = {{AW{1'b1}}} & {{(AW-3){1'b1}}, cmd_level};
   wire [AW-1:0] breakpoint_instruction_addr = {AW{1'b0}};

   always @(posedge core_clk) begin
      if (!nrst) begin
         run_reg     <= 1'b0;
         kind_reg    <= `BMC_KIND_WRITE;
         st_reg      <= `BMC_S0;
         wait_reg    <= 1'b0;
         fault_reg   <= 1'b0;
         word_reg    <= 1'b0;
         bsel_reg    <= 1'b0;
         addr_reg    <= {AW{1'b0}};
         wdata_reg   <= 16'h0000;
         byte_reg    <= 8'h00;
         level_reg   <= 3'h0;
         done        <= 1'b0;
         done_fault  <= 1'b0;
         done_periph <= 1'b0;
         rd_byte     <= 8'h00;
         vector_num  <= 8'h00;
         addr_out    <= {AW{1'b0}};
         addr_oe_n   <= 1'b1;
         data_out    <= 16'h0000;
         data_oe_n   <= 1'b1;
         address_valid_strobe_n <= 1'b1;
         upper_byte_strobe_n    <= 1'b1;
         lower_byte_strobe_n    <= 1'b1;
         rw_read               <= 1'b1;
         cycle_class_codes     <= 3'h0;
      end else begin
         done        <= 1'b0;
         done_fault  <= 1'b0;
         done_periph <= 1'b0;
         if (start) begin
            run_reg   <= 1'b1;
            kind_reg  <= cmd_kind;
            st_reg    <= `BMC_S0;
            wait_reg  <= 1'b0;
            fault_reg <= 1'b0;
            // The atomic cycle is always a single byte.
            word_reg  <= cmd_word & (cmd_kind == `BMC_KIND_WRITE);
            bsel_reg  <= cmd_byte_select_bit;
            wdata_reg <= cmd_wdata;
            level_reg <= cmd_level;
            done_periph <= 1'b0;
            if (cmd_kind == `BMC_KIND_IACK || cmd_kind == `BMC_KIND_BREAKPOINT_INSTRUCTION) begin
               cycle_class_codes <= `BMC_CODES_CPU;
               if (cmd_kind == `BMC_KIND_IACK)
                  addr_reg <= iack_addr;
               else
                  addr_reg <= breakpoint_instruction_addr;
               addr_reg[`BMC_TYPE_LSB+3 -: 4] <= (cmd_kind == `BMC_KIND_IACK) ?
                  `BMC_TYPE_IACK : `BMC_TYPE_BREAKPOINT_INSTRUCTION;
            end else begin
               cycle_class_codes <= cmd_class;
               addr_reg <= cmd_addr;
            end
            rw_read <= 1'b1;
         end else if (run_reg && tick) begin
            if (st_reg == wait_st && (wait_reg || !term_s)) begin
               // Hold the wait state for whole clocks only.
               wait_reg <= ~wait_reg;
            end else if (st_reg == end_st) begin
               // Rising edge closing the cycle: release the buses.
               run_reg   <= 1'b0;
               addr_oe_n <= 1'b1;
               data_oe_n <= 1'b1;
               rw_read   <= 1'b1;
               address_valid_strobe_n <= 1'b1;
               done       <= 1'b1;
               done_fault <= fault_reg;
            end else begin
               st_reg <= st_reg + 5'h01;
               if (st_reg == wait_st) begin
                  fault_reg   <= fault_s & ~ack_s;
                  done_periph <= 1'b0;
                  if (periph_s && !ack_s && !fault_s) begin
                     // Peripheral handshake takes over; vector is base plus level, done_periph stays low.
                     vector_num <= `BMC_AUTOVEC_BASE + {5'h00, level_reg};
                  end
                  wait_reg <= 1'b0;
               end
               case (st_reg + 5'h01)
                  `BMC_S1: begin
                     addr_out  <= addr_reg;
                     addr_oe_n <= 1'b0;
                  end
                  `BMC_S2: begin
                     address_valid_strobe_n <= 1'b0;
                     if (is_write) begin
                        rw_read <= 1'b0;
                     end else begin
                        upper_byte_strobe_n <= ~uds_on;
                        lower_byte_strobe_n <= ~lds_on;
                     end
                  end
                  `BMC_S3: begin
                     if (is_write) begin
                        data_out  <= word_reg ? wdata_reg :
                                     {wdata_reg[7:0], wdata_reg[7:0]};
                        data_oe_n <= 1'b0;
                     end
                  end
                  `BMC_S4: begin
                     if (is_write) begin
                        upper_byte_strobe_n <= ~uds_on;
                        lower_byte_strobe_n <= ~lds_on;
                     end
                  end
                  `BMC_S14: rw_read <= 1'b0;
                  `BMC_S15: begin
                     data_out  <= {tas_byte, tas_byte};
                     data_oe_n <= 1'b0;
                  end
                  `BMC_S16: begin
                     upper_byte_strobe_n <= ~uds_on;
                     lower_byte_strobe_n <= ~lds_on;
                  end
                  default: begin
                     // S8 to S13 leave the pins as they are.
                  end
               endcase
               if (st_reg + 5'h01 == neg_st) begin
                  upper_byte_strobe_n <= 1'b1;
                  lower_byte_strobe_n <= 1'b1;
                  // The atomic read keeps the address strobe low.
                  if (!(is_rmw && !rmw_wr && !fault_reg))
                     address_valid_strobe_n <= 1'b1;
                  if (!is_write && !rmw_wr) begin
                     byte_reg <= lane_byte;
                     rd_byte  <= lane_byte;
                     // Only the low byte carries a vector; D15..D8 are ignored.
                     if (is_iack && !periph_reg)
                        vector_num <= data_in[7:0];
                  end
               end
               if (st_reg == wait_st && periph_s && !ack_s && !fault_s)
                  done_periph <= 1'b0;
            end
         end
      end
   end

   // Peripheral termination is remembered so the acknowledge keeps the base-plus-level vector.
   reg periph_reg;

   always @(posedge core_clk) begin
      if (!nrst)
         periph_reg <= 1'b0;
      else if (start)
         periph_reg <= 1'b0;
      else if (run_reg && tick && st_reg == wait_st && !wait_reg &&
               periph_s && !ack_s && !fault_s)
         periph_reg <= 1'b1;
   end

   // ======================================================================
   // Bus arbitration, grant side
   // ======================================================================
   always @(posedge core_clk) begin
      if (!nrst) begin
         arb_reg     <= ARB_IDLE;
         arb_cnt_reg <= 4'h0;
         grant_acknowledge_d_reg <= 1'b0;
         bus_grant_n <= 1'b1;
      end else begin
         grant_acknowledge_d_reg <= grant_acknowledge_s;
         case (arb_reg)
            ARB_IDLE: begin
               // Grant waits until any started cycle shows its strobe.
               if (br_s && bus_free_for_grant) begin
                  arb_reg     <= ARB_GRANT;
                  bus_grant_n <= 1'b0;
               end
            end
            ARB_GRANT: begin
               arb_cnt_reg <= 4'h0;
               if (!three_s) begin
                  // Two-wire: hold grant while the master still requests.
                  if (!br_s) begin
                     arb_reg     <= ARB_IDLE;
                     bus_grant_n <= 1'b1;
                  end
               end else if (grant_acknowledge_s && !grant_acknowledge_d_reg) begin
                  arb_reg <= ARB_ACKED;
               end else if (!br_s) begin
                  arb_reg     <= grant_acknowledge_s ? ARB_HELD : ARB_IDLE;
                  bus_grant_n <= 1'b1;
               end
            end
            ARB_ACKED: begin
               if (arb_cnt_reg == GRANT_NEG - 4'h1) begin
                  arb_reg     <= ARB_HELD;
                  arb_cnt_reg <= 4'h0;
                  bus_grant_n <= 1'b1;
               end else begin
                  arb_cnt_reg <= arb_cnt_reg + 4'h1;
               end
            end
            ARB_HELD: begin
               if (br_s) begin
                  if (arb_cnt_reg == GRANT_REASSERT - 4'h1) begin
                     arb_reg     <= ARB_GRANT;
                     bus_grant_n <= 1'b0;
                  end else begin
                     arb_cnt_reg <= arb_cnt_reg + 4'h1;
                  end
               end else if (!grant_acknowledge_s) begin
                  arb_reg     <= ARB_IDLE;
                  arb_cnt_reg <= 4'h0;
               end
            end
            default: begin
               arb_reg     <= ARB_IDLE;
               bus_grant_n <= 1'b1;
            end
         endcase
      end
   end

   // ======================================================================
   // Request acceptance and control-pin drive
   // ======================================================================
   // No new cycle starts while another master holds or is being given the bus.
   always @(posedge core_clk) begin
      if (!nrst) begin
         cmd_ready <= 1'b0;
         ctl_oe_n  <= 1'b0;
      end else begin
         cmd_ready <= ~run_reg & ~start & ~done & (arb_reg == ARB_IDLE) & ~br_s;
         ctl_oe_n  <= (arb_reg != ARB_IDLE) & ~run_reg;
      end
   end

   wire unused_flag = periph_reg & done_periph;

endmodule // bmc_master

// File: bmc_master_assertions.sv
// Concurrent checks on the ports of the bus-master cycle sequencer.
// Assumes the core holds the cmd fields steady until done.
`timescale 1ns/100ps
module bmc_master_chk #(parameter AW = 23) (
   // Clock, reset and core request
   input wire          core_clk,
   input wire          nrst,
   input wire          cmd_valid,
   input wire          cmd_ready,
   input wire [1:0]    cmd_kind,
   input wire          cmd_word,
   input wire          cmd_byte_select_bit,
   input wire [2:0]    cmd_level,
   // Bus pins
   input wire [AW-1:0] addr_out,
   input wire          addr_oe_n,
   input wire          data_oe_n,
   input wire          address_valid_strobe_n,
   input wire          upper_byte_strobe_n,
   input wire          lower_byte_strobe_n,
   input wire          rw_read,
   input wire [2:0]    cycle_class_codes,
   // Arbitration pins
   input wire          three_wire_mode,
   input wire          bus_request_n,
   input wire          grant_acknowledge_n,
   input wire          bus_grant_n
);
// ======
default clocking @(posedge core_clk); endclocking
default disable iff (!nrst);
wire take = cmd_valid && cmd_ready;
wire strb_n = upper_byte_strobe_n && lower_byte_strobe_n;
sequence s_lanes(u, l);
   ##[1:12] (upper_byte_strobe_n == u && lower_byte_strobe_n == l);
endsequence
// The atomic read part ends with the strobes off but the address strobe kept.
sequence s_read_end;
   !address_valid_strobe_n && $rose(strb_n);
endsequence
a_word_lanes: assert property (take && cmd_kind == 2'h0 && cmd_word |-> s_lanes(0, 0))
   else $error("word write lanes wrong");
a_byte_lane: assert property (take && cmd_kind == 2'h0 && !cmd_word
   |-> s_lanes(cmd_byte_select_bit, !cmd_byte_select_bit)) else $error("byte lane wrong");
a_strobe_in_as: assert property (!strb_n |-> !address_valid_strobe_n)
   else $error("byte strobe outside address strobe");
a_data_writes: assert property (!data_oe_n |-> !rw_read)
   else $error("data driven in read direction");
a_rmw_hold: assert property (s_read_end |=> ($stable(addr_out) && $stable(rw_read)
   && $stable(cycle_class_codes) && !address_valid_strobe_n && strb_n)[*5])
   else $error("bus moved during modify");
a_rmw_write: assert property (s_read_end |-> (!address_valid_strobe_n)
   throughout (##[6:12] $fell(rw_read))) else $error("atomic write part wrong");
a_end_float: assert property ($rose(address_valid_strobe_n)
   |-> ##[1:3] (addr_oe_n && data_oe_n && rw_read)) else $error("bus not released");
a_iack_addr: assert property (take && cmd_kind == 2'h2 |-> ##[1:8]
   ($fell(address_valid_strobe_n) && cycle_class_codes == 3'h7 && !strb_n
   && addr_out == {{(AW-3){1'b1}}, cmd_level} && !upper_byte_strobe_n))
   else $error("interrupt acknowledge wrong");
a_grant_drop: assert property (three_wire_mode && !bus_grant_n
   && $fell(grant_acknowledge_n) |-> ##[2:10] bus_grant_n) else $error("grant kept");
a_grant_hold: assert property (!three_wire_mode && !bus_grant_n && !bus_request_n
   |=> !bus_grant_n) else $error("two-wire grant dropped early");
endmodule // bmc_master_chk
bind bmc_master bmc_master_chk #(.AW(AW)) bmc_master_chk_i (.core_clk, .nrst, .cmd_valid,
   .cmd_ready, .cmd_kind, .cmd_word, .cmd_byte_select_bit, .cmd_level, .addr_out, .addr_oe_n,
   .data_oe_n, .address_valid_strobe_n, .upper_byte_strobe_n, .lower_byte_strobe_n,
   .rw_read, .cycle_class_codes, .three_wire_mode, .bus_request_n, .grant_acknowledge_n,
   .bus_grant_n);

// File: bmc_slave_model.sv
// Slave on the far side: answers each strobed cycle after dly clocks.
// Assumes the bench picks the termination kind before each cycle.
`timescale 1ns/100ps
module bmc_slave_model (
   // Bus side
   input wire        core_clk,
   input wire        upper_byte_strobe_n,
   input wire        lower_byte_strobe_n,
   input wire        rw_read,
   output reg        transfer_acknowledge_n = 1'b1,
   output reg        bus_fault_input_n = 1'b1,
   output reg        autovector_request_n = 1'b1,
   output wire [15:0] data_in,
   // Bench control: 0 acknowledge, 1 fault, 2 autovector
   input wire [1:0]  term_sel,
   input wire [3:0]  dly,
   input wire [15:0] rdata
);
// ======
reg [3:0] cnt_reg = 4'h0;
wire sel = !(upper_byte_strobe_n && lower_byte_strobe_n);
always @(negedge core_clk) begin
   if (!sel) begin
      cnt_reg <= 4'h0;
      transfer_acknowledge_n <= 1'b1;
      bus_fault_input_n <= 1'b1;
      autovector_request_n <= 1'b1;
   end else if (cnt_reg == dly) begin
      transfer_acknowledge_n <= (term_sel != 2'h0);
      bus_fault_input_n <= (term_sel != 2'h1);
      autovector_request_n <= (term_sel != 2'h2);
   end else begin
      cnt_reg <= cnt_reg + 4'h1;
   end
end
// A released bus shows inverted data so a late capture cannot match by luck.
assign data_in = (sel && rw_read) ? rdata : ~rdata;
endmodule // bmc_slave_model

// File: bmc_master_tb.sv
// Self-checking bench for the bus-master cycle sequencer.
// Assumes bmc_master and bmc_slave_model are compiled with it.
`timescale 1ns/100ps
module bmc_master_tb;
// ======
reg core_clk = 0, nrst = 0, cmd_valid = 0, cmd_word = 0, cmd_byte_select_bit = 0;
reg [1:0] cmd_kind = 0, term_sel = 0;
reg [2:0] cmd_class = 3'h5, cmd_level = 0, sc;
reg [3:0] dly = 0;
reg [22:0] cmd_addr = 23'h12345, sa;
reg [15:0] cmd_wdata = 0, rdata = 0, sd;
reg three_wire_mode = 0, bus_request_n = 1, grant_acknowledge_n = 1;
reg su, sl, pa, vpa_n = 1;
wire cmd_ready, done, done_fault, addr_oe_n, data_oe_n, address_valid_strobe_n, rw_read;
wire upper_byte_strobe_n, lower_byte_strobe_n, bus_grant_n, transfer_acknowledge_n;
wire bus_fault_input_n, autovector_request_n;
wire [7:0] rd_byte, vector_num;
wire [22:0] addr_out;
wire [15:0] data_out, data_in;
wire [2:0] cycle_class_codes;
integer num_errors = 0, check_count = 0, ticks, nfall, t0;
always #20 core_clk = ~core_clk;
bmc_master bmc_master_i (.core_clk, .nrst, .cmd_valid, .cmd_kind, .cmd_word,
   .cmd_byte_select_bit, .cmd_addr, .cmd_class, .cmd_level, .cmd_wdata, .cmd_ready, .done,
   .done_fault, .done_periph(), .rd_byte, .vector_num, .addr_out, .addr_oe_n, .data_out,
   .data_oe_n, .data_in, .address_valid_strobe_n, .upper_byte_strobe_n, .lower_byte_strobe_n,
   .rw_read, .cycle_class_codes, .ctl_oe_n(), .transfer_acknowledge_n, .bus_fault_input_n,
   .legacy_peripheral_valid_n(vpa_n), .autovector_request_n, .three_wire_mode,
   .bus_request_n, .grant_acknowledge_n, .bus_grant_n);
bmc_slave_model bmc_slave_model_i (.core_clk, .upper_byte_strobe_n, .lower_byte_strobe_n,
   .rw_read, .transfer_acknowledge_n, .bus_fault_input_n, .autovector_request_n, .data_in,
   .term_sel, .dly, .rdata);
task chk(input string nm, input logic [22:0] e, input logic [22:0] g);
   check_count = check_count + 1;
   if (g !== e) begin
      num_errors = num_errors + 1;
      $display("BAD %s expected %h seen %h", nm, e, g);
   end
endtask
task end_sim;
   $display("checks %0d errors %0d", check_count, num_errors);
   if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
   else $display("RESULT: FAIL");
   $finish;
endtask
// One whole cycle; records lanes, data, address and codes seen on the pins.
task run(input [1:0] k, input w, s, input [15:0] wd, rd, input [1:0] ts, input [3:0] dl);
   {cmd_kind, cmd_word, cmd_byte_select_bit, cmd_wdata, rdata} = {k, w, s, wd, rd};
   {term_sel, dly, su, sl, sd, nfall, ticks, pa} = {ts, dl, 2'b00, 16'h0, 64'h0, 1'b1};
   repeat (20) if (cmd_ready !== 1'b1) @(negedge core_clk);
   cmd_valid = 1;
   @(negedge core_clk);
   cmd_valid = 0;
   while (done !== 1'b1 && ticks < 100) begin
      if (!upper_byte_strobe_n) su = 1;
      if (!lower_byte_strobe_n) sl = 1;
      if (!data_oe_n) sd = data_out;
      if (!address_valid_strobe_n) {sa, sc} = {addr_out, cycle_class_codes};
      if (pa && !address_valid_strobe_n) nfall = nfall + 1;
      pa = address_valid_strobe_n;
      @(negedge core_clk);
      ticks = ticks + 1;
   end
   chk("done", 1, done);
endtask
task t_write;
   run(0, 1, 0, 16'hA55A, 0, 0, 0);
   t0 = ticks;
   chk("word lanes", 2'b11, {su, sl});
   chk("word data", 16'hA55A, sd);
   chk("address", 23'h12345, sa);
   chk("class", 3'h5, sc);
   run(0, 0, 0, 16'h0066, 0, 0, 4'h5);
   chk("upper lane", 2'b10, {su, sl});
   chk("wait parity", 0, (ticks - t0) & 1);
   chk("waited", 1, ticks > t0);
   run(0, 0, 1, 16'h0077, 0, 1, 0);
   chk("lower lane", 2'b01, {su, sl});
   chk("fault flag", 1, done_fault);
   chk("fault length", t0 + 2, ticks);
endtask
task t_rmw;
   run(1, 0, 1, 0, 16'h5531, 0, 0);
   chk("fetched", 8'h31, rd_byte);
   chk("written", 8'hB1, sd[7:0]);
   chk("one strobe", 1, nfall);
   chk("rmw lanes", 2'b01, {su, sl});
endtask
task t_cpu;
   cmd_level = 3'h5;
   run(2, 0, 0, 0, 16'hAB40, 0, 0);
   chk("vector", 8'h40, vector_num);
   chk("iack addr", {20'hFFFFF, 3'h5}, sa);
   chk("iack codes", 3'h7, sc);
   chk("iack lanes", 2'b11, {su, sl});
   cmd_level = 3'h3;
   run(2, 0, 0, 0, 16'hAB40, 2, 0);
   chk("autovector", 8'h1B, vector_num);
   cmd_level = 3'h6;
   vpa_n = 0;
   run(2, 0, 0, 0, 16'hAB40, 3, 0);
   vpa_n = 1;
   chk("peripheral vector", 8'h1E, vector_num);
   run(3, 0, 0, 16'h1234, 0, 0, 0);
   chk("breakpoint_instruction type", 0, sa[18:15]);
   chk("breakpoint_instruction codes", 3'h7, sc);
   chk("breakpoint_instruction data", 0, sd);
endtask
task wait_g(input v);
   repeat (12) if (bus_grant_n !== v) @(negedge core_clk);
   chk("grant", v, bus_grant_n);
endtask
task t_arb;
   bus_request_n = 0;
   wait_g(0);
   repeat (6) @(negedge core_clk);
   chk("grant held", 0, bus_grant_n);
   bus_request_n = 1;
   wait_g(1);
   three_wire_mode = 1;
   bus_request_n = 0;
   wait_g(0);
   chk("bus idle", 1, address_valid_strobe_n);
   grant_acknowledge_n = 0;
   wait_g(1);
   wait_g(0);
   bus_request_n = 1;
   grant_acknowledge_n = 1;
   wait_g(1);
endtask
initial begin
   repeat (3) @(negedge core_clk);
   nrst = 1;
   repeat (2) @(negedge core_clk);
   t_write;
   t_rmw;
   t_cpu;
   t_arb;
   end_sim;
end
// The tests need well under a thousand clocks; ten thousand means a hang.
initial begin
   #400000;
   num_errors = num_errors + 1;
   end_sim;
end
endmodule // bmc_master_tb
